// ==== verilog/selftest_pkg.sv ====
// package of constants and carriers for the memory self-test block
// assumes a 16-bit register port with a 14-bit word address
package selftest_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [13:0] ctrl_addr     = 14'h014d; // self-test control
	localparam logic [13:0] ident_addr    = 14'h3fff; // identification
	localparam logic [15:0] ctrl_reset    = 16'h0000; // control reset value

	// ****************************************
	// control field positions
	// ****************************************
	localparam int          mode_bit      = 12;       // test mode enable
	localparam int          bp_data_base  = 9;        // go at +2, done +1
	localparam int          loc_data_base = 6;        // pass at +0
	localparam int          bp_conn_base  = 3;
	localparam int          loc_conn_base = 0;
	localparam int          mem_count     = 4;        // memories under test

	// ****************************************
	// identification fields
	// ****************************************
	localparam logic [3:0]  revision_val  = 4'h5;     // arbitrary value
	localparam logic [2:0]  part_code_val = 3'h6;     // arbitrary value

	// ****************************************
	// engine timing
	// ****************************************
	localparam logic [7:0]  engine_cycles = 8'h40;    // walk length

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed
	{
		logic        rd;     // read strobe
		logic        wr;     // write strobe
		logic [13:0] addr;   // word address
		logic [15:0] wdata;  // write data
	} reg_req_type;

	typedef struct packed
	{
		logic [3:0] done;    // per-memory completion
		logic [3:0] pass;    // per-memory result
	} test_status_type;

endpackage : selftest_pkg

// ==== verilog/selftest_engine.sv ====
// one memory test engine: counts a walk and checks compare results
// assumes mem_fail comes from the memory's compare logic on clk
`timescale 1ns/1ps
`default_nettype none
module selftest_engine
(
	input  wire logic clk,       // system clock
	input  wire logic reset,     // sync reset, active high
	input  wire logic start,     // one-cycle launch pulse
	input  wire logic mem_fail,  // compare mismatch this cycle
	output var  logic done,      // walk finished
	output var  logic pass,      // no mismatch seen
	output var  logic busy       // walk in progress
);

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [2:0]
	{
		idle_st = 3'b001,
		run_st  = 3'b010,
		fin_st  = 3'b100
	} eng_state_type;

	eng_state_type state_reg;    // engine state
	logic [7:0]    count_reg;    // walk address
	logic          err_reg;      // mismatch seen

	// state sequencing
	always_ff @(posedge clk)
	begin
		if (reset)
			state_reg <= idle_st;
		else
			case (state_reg)
				idle_st: if (start) state_reg <= run_st;
				run_st:
					if (count_reg == selftest_pkg::engine_cycles - 8'h01)
						state_reg <= fin_st;
				fin_st:  state_reg <= start ? run_st : fin_st;
				default: state_reg <= idle_st;
			endcase
	end

	// walk counter and error capture
	always_ff @(posedge clk)
	begin
		if (reset || start)
		begin
			count_reg <= 8'h00;
			err_reg   <= 1'b0;
		end
		else if (state_reg == run_st)
		begin
			count_reg <= count_reg + 8'h01;
			err_reg   <= err_reg | mem_fail;
		end
	end

	// flags hold until the next launch
	always_ff @(posedge clk)
	begin
		if (reset || start)
		begin
			done <= 1'b0;
			pass <= 1'b0; // RULE12
		end
		else if (state_reg == run_st &&
			count_reg == selftest_pkg::engine_cycles - 8'h01)
		begin
			done <= 1'b1;                  // RULE5
			pass <= ~(err_reg | mem_fail); // RULE6
		end
	end

	assign busy = (state_reg == run_st);

endmodule : selftest_engine
`default_nettype wire

// ==== verilog/memory_self_test.sv ====
// memory self-test control register and identification register
// assumes a synchronous register port on clk and compare inputs on clk
// Function
// [RULE1] software arms mode first, then sets go
// [RULE2] bit 12 high enters self-test mode
// [RULE3] software writes zero to bits 15:13
// [RULE4] backplane data test starts on rising go
// [RULE5] bit 10 shows backplane data completion
// [RULE6] bit 9 shows backplane data pass
// [RULE7] local data: go 8, done 7, pass 6
// [RULE8] backplane conn: go 5, done 4, pass 3
// [RULE9] local conn: go 2, done 1, pass 0
// [RULE10] identity: revision 7:4, part code 2:0
// [RULE11] identity reserved bits read zero
// [RULE12] go ignored outside mode; flags hold
`timescale 1ns/1ps
`default_nettype none
module memory_self_test
(
	input  wire logic                        clk,       // 50 MHz clock
	input  wire logic                        reset,     // sync, high
	input  wire selftest_pkg::reg_req_type   req,       // register access
	input  wire logic [3:0]                  mem_fail,  // compare errors
	output var  logic [15:0]                 rdata,     // read data
	output var  logic                        selftest_mode_enable, // mode
	output var  logic [3:0]                  mem_busy   // walks running
);

	// ****************************************
	// storage
	// ****************************************
	logic [15:12]                  ctrl_reg;   // mode and reserved bits
	logic [3:0]                    go_reg;     // go bits as written
	logic [3:0]                    start_next; // launch pulses
	logic [3:0]                    busy_w;     // engine busy
	selftest_pkg::test_status_type stat;       // engine flags
	logic [3:0]                    go_wdata;   // go bits of write

	// go bits per memory, ordered local conn .. backplane data
	assign go_wdata = {req.wdata[selftest_pkg::bp_data_base + 2],
		req.wdata[selftest_pkg::loc_data_base + 2],
		req.wdata[selftest_pkg::bp_conn_base + 2],
		req.wdata[selftest_pkg::loc_conn_base + 2]};

	// ****************************************
	// control register write
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (reset)
			ctrl_reg <= selftest_pkg::ctrl_reset[15:12];
		else if (req.wr && req.addr == selftest_pkg::ctrl_addr)
			ctrl_reg <= req.wdata[15:12]; // low bits are go and flags
	end

	// remembered go levels for edge detection
	always_ff @(posedge clk)
	begin
		if (reset)
			go_reg <= 4'h0;
		else if (req.wr && req.addr == selftest_pkg::ctrl_addr)
			go_reg <= go_wdata;
	end

	// rising go while mode was armed and the write keeps mode set launches a walk
	always_comb
	begin
		start_next = 4'h0;
		if (req.wr && req.addr == selftest_pkg::ctrl_addr &&
			ctrl_reg[selftest_pkg::mode_bit] &&                 // RULE1
			req.wdata[selftest_pkg::mode_bit])                  // RULE12
			start_next = go_wdata & ~go_reg;                    // RULE4
	end

	// ****************************************
	// engines, one per memory
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < selftest_pkg::mem_count; g++)
		begin : eng_g
			selftest_engine u_eng
			(
				.clk      (clk),
				.reset    (reset),
				.start    (start_next[g]), // RULE7 RULE8 RULE9
				.mem_fail (mem_fail[g]),
				.done     (stat.done[g]),
				.pass     (stat.pass[g]),
				.busy     (busy_w[g])
			);
		end
	endgenerate

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			selftest_mode_enable <= 1'b0;
			mem_busy             <= 4'h0;
		end
		else
		begin
			selftest_mode_enable <= ctrl_reg[selftest_pkg::mode_bit]; // RULE2
			mem_busy             <= busy_w;
		end
	end

	// registered read data
	always_ff @(posedge clk)
	begin
		if (reset || !req.rd)
			rdata <= 16'h0000;
		else if (req.addr == selftest_pkg::ctrl_addr)
			rdata <= {ctrl_reg[15:12],
				go_reg[3], stat.done[3], stat.pass[3],   // RULE5 RULE6
				go_reg[2], stat.done[2], stat.pass[2],   // RULE7
				go_reg[1], stat.done[1], stat.pass[1],   // RULE8
				go_reg[0], stat.done[0], stat.pass[0]};  // RULE9
		else if (req.addr == selftest_pkg::ident_addr)
			rdata <= {8'h00, selftest_pkg::revision_val, 1'b0,
				selftest_pkg::part_code_val};           // RULE10 RULE11
		else
			rdata <= 16'h0000;
	end

	// ****************************************
	// checks: read path
	// ****************************************
	// identity fields come from the package constants
	ident_read_a: assert property ( // RULE10
		@(posedge clk) disable iff (reset)
		req.rd && req.addr == selftest_pkg::ident_addr |=>
		rdata[7:0] == {selftest_pkg::revision_val, 1'b0,
			selftest_pkg::part_code_val})
		else $error("bad identity read");
	// reserved identity positions never carry data
	ident_resv_a: assert property ( // RULE11
		@(posedge clk) disable iff (reset)
		req.rd && req.addr == selftest_pkg::ident_addr |=>
		rdata[15:8] == 8'h00 && !rdata[3])
		else $error("identity reserved nonzero");
	// control read shows the backplane data flags of the cycle before
	ctrl_read_a: assert property ( // RULE5 RULE6
		@(posedge clk) disable iff (reset)
		req.rd && req.addr == selftest_pkg::ctrl_addr |=>
		rdata[10] == $past(stat.done[3]) &&
		rdata[9] == $past(stat.pass[3]))
		else $error("control flags misread");
	// mode output follows a write two edges later
	mode_out_a: assert property ( // RULE2
		@(posedge clk) disable iff (reset)
		req.wr && req.addr == selftest_pkg::ctrl_addr |=> ##1
		selftest_mode_enable == $past(req.wdata[12], 2))
		else $error("mode output wrong");

	// ****************************************
	// checks: launch
	// ****************************************
	// no launch while the stored mode bit is low
	no_start_off_a: assert property ( // RULE12
		@(posedge clk) disable iff (reset)
		!ctrl_reg[12] |-> start_next == 4'h0)
		else $error("launch outside mode");
	// a go bit that stays high does not launch again
	level_once_a: assert property ( // RULE4
		@(posedge clk) disable iff (reset)
		start_next[3] |-> !go_reg[3])
		else $error("level retriggered");
	// a launch clears the old flags and starts the walk
	launch_clear_a: assert property ( // RULE9
		@(posedge clk) disable iff (reset)
		start_next[0] |=>
		busy_w[0] && !stat.done[0] && !stat.pass[0])
		else $error("loc conn launch lost");

	// ****************************************
	// checks: completion
	// ****************************************
	// done appears one walk length after the launch edge
	bp_done_a: assert property ( // RULE5
		@(posedge clk) disable iff (reset)
		start_next[3] |=> ##64 stat.done[3])
		else $error("bp data not done");
	loc_done_a: assert property ( // RULE7
		@(posedge clk) disable iff (reset)
		start_next[2] |=> ##64 stat.done[2])
		else $error("loc data not done");
	loc_conn_done_a: assert property ( // RULE9
		@(posedge clk) disable iff (reset)
		start_next[0] |=> ##64 stat.done[0])
		else $error("loc conn not done");
	// done cleared first, then set inside a window
	conn_done_a: assert property ( // RULE8
		@(posedge clk) disable iff (reset)
		start_next[1] |=> !stat.done[1] ##[60:70] stat.done[1])
		else $error("bp conn not done");
	// sixty-four clean compare cycles, as eight runs of eight
	sequence bp_clean_s;
		(!mem_fail[3] && !start_next[3]) [*8];
	endsequence
	// a walk without mismatch ends in a pass
	bp_pass_a: assert property ( // RULE6
		@(posedge clk) disable iff (reset)
		start_next[3] ##1 bp_clean_s ##1 bp_clean_s ##1 bp_clean_s
		##1 bp_clean_s ##1 bp_clean_s ##1 bp_clean_s ##1 bp_clean_s
		##1 bp_clean_s |=> stat.done[3] && stat.pass[3])
		else $error("bp data false fail");
	// a mismatch during the walk ends in a failed result
	loc_fail_a: assert property ( // RULE9
		@(posedge clk) disable iff (reset)
		busy_w[0] && mem_fail[0] |->
		##[1:64] (stat.done[0] && !stat.pass[0]))
		else $error("loc conn fail lost");
	data_fail_a: assert property ( // RULE7
		@(posedge clk) disable iff (reset)
		busy_w[2] && mem_fail[2] |->
		##[1:64] (stat.done[2] && !stat.pass[2]))
		else $error("loc data fail lost");
	// flags hold between launches
	flag_hold_a: assert property ( // RULE12
		@(posedge clk) disable iff (reset)
		stat.done[2] && !start_next[2] |=> stat.done[2])
		else $error("done flag lost");
	pass_hold_a: assert property ( // RULE12
		@(posedge clk) disable iff (reset)
		stat.pass[3] && !start_next[3] |=> stat.pass[3])
		else $error("pass flag lost");

	// ****************************************
	// covers
	// ****************************************
	launch_c: cover property (@(posedge clk) start_next != 4'h0);
	all_start_c: cover property (@(posedge clk) start_next == 4'hf);
	pass_c: cover property (@(posedge clk) stat.done[3] && stat.pass[3]);
	fail_c: cover property (@(posedge clk) stat.done[0] && !stat.pass[0]);

endmodule : memory_self_test
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the memory self-test register block
// assumes the design package is compiled first; no partner model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ****************************************
	// signals and counters
	// ****************************************
	logic                      clk;       // system clock
	logic                      reset;     // sync reset
	selftest_pkg::reg_req_type req;       // register request
	logic [3:0]                mem_fail;  // compare errors
	logic [15:0]               rdata;     // read data
	logic                      mode;      // test mode output
	logic [3:0]                mem_busy;  // walks running
	int                        n_fail;    // mismatches
	int                        tests_run; // comparisons
	logic [15:0]               d;         // last read value
	int                        i;         // loop index
	localparam logic [15:0] ident_exp = {8'h00, selftest_pkg::revision_val,
		1'b0, selftest_pkg::part_code_val}; // identity read value
	typedef struct { logic w; logic [13:0] a; logic [15:0] wd, exp; } row_type;
	row_type rows [4] = '{
		'{1'b0, 14'h3fff, 16'h0000, ident_exp}, // identity value
		'{1'b1, 14'h3fff, 16'hffff, ident_exp}, // write ignored
		'{1'b0, 14'h0000, 16'h0000, 16'h0000}, // unmapped reads zero
		'{1'b1, 14'h014d, 16'h1000, 16'h1000}  // arm test mode
	};
	memory_self_test i_memory_self_test
	(
		.clk                  (clk),
		.reset                (reset),
		.req                  (req),
		.mem_fail             (mem_fail),
		.rdata                (rdata),
		.selftest_mode_enable (mode),
		.mem_busy             (mem_busy)
	);
	// ****************************************
	// clock, bus cycles and compares
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wr(input logic [13:0] a, input logic [15:0] v);
		@(posedge clk); #1;
		req = '{1'b0, 1'b1, a, v};
		@(posedge clk); #1;
		req.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [13:0] a);
		@(posedge clk); #1;
		req = '{1'b1, 1'b0, a, 16'h0000};
		@(posedge clk); #1;
		d = rdata;
		req.rd = 1'b0;
	endtask : rd
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %0t read %h expected %h", $time, g, e);
		end
	endtask : chk16
	task automatic chk4(input logic [3:0] g, input logic [3:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %0t flags %b expected %b", $time, g, e);
		end
	endtask : chk4
	// poll control until the given done bits rise, bounded
	task automatic poll(input logic [15:0] m);
		for (int k = 0; k < 200; k++)
		begin
			rd(14'h014d);
			if ((d & m) === m) return;
		end
		n_fail++;
		$display("ERROR %0t completion never seen", $time);
		test_done();
	endtask : poll
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		n_fail = 0;
		tests_run = 0;
		reset = 1'b1;
		req = '0;
		mem_fail = 4'h0;
		repeat (5) @(posedge clk);
		#1 reset = 1'b0;
		rd(14'h014d);
		chk16(d, selftest_pkg::ctrl_reset);
		chk4({3'h0, mode}, 4'h0);
		// table of plain accesses
		for (i = 0; i < 4; i++)
		begin
			if (rows[i].w) wr(rows[i].a, rows[i].wd);
			rd(rows[i].a);
			chk16(d, rows[i].exp);
		end
		chk4({3'h0, mode}, 4'h1);
		// second write launches backplane data
		wr(14'h014d, 16'h1800);
		@(posedge clk); #1;
		chk4(mem_busy, 4'h8);
		poll(16'h0400);
		chk16(d, 16'h1e00);
		// go held high must not retrigger
		wr(14'h014d, 16'h1800);
		@(posedge clk); #1;
		chk4(mem_busy, 4'h0);
		// relaunch all four, two memories failing
		mem_fail = 4'h5;
		wr(14'h014d, 16'h1000);
		wr(14'h014d, 16'h1924);
		@(posedge clk); #1;
		chk4(mem_busy, 4'hf);
		poll(16'h0492);
		chk16(d, 16'h1fbe);
		mem_fail = 4'h0;
		// mode off: go ignored, flags hold
		wr(14'h014d, 16'h0000);
		repeat (2) @(posedge clk);
		#1 chk4({3'h0, mode}, 4'h0);
		wr(14'h014d, 16'h0924);
		@(posedge clk); #1;
		chk4(mem_busy, 4'h0);
		rd(14'h014d);
		chk16(d, 16'h0fbe);
		// arming and go in one write must not launch
		wr(14'h014d, 16'h0000);
		wr(14'h014d, 16'h1924);
		@(posedge clk); #1;
		chk4(mem_busy, 4'h0);
		// reset in mid-walk
		wr(14'h014d, 16'h1000);
		wr(14'h014d, 16'h1020);
		@(posedge clk); #1;
		chk4(mem_busy, 4'h2);
		reset = 1'b1;
		repeat (5) @(posedge clk);
		#1 reset = 1'b0;
		chk4(mem_busy, 4'h0);
		chk4({3'h0, mode}, 4'h0);
		rd(14'h014d);
		chk16(d, selftest_pkg::ctrl_reset);
		// walks run again after reset
		wr(14'h014d, 16'h1000);
		wr(14'h014d, 16'h1004);
		poll(16'h0002);
		chk16(d, 16'h1007);
		test_done();
	end
endmodule : testbench
`default_nettype wire
